// ==== rtl/ewu_pkg.sv ====
/*
  ewu_pkg: shared constants and types for the extended write and
  uncorrectable marking command block.
  assumes: used by ewu_top and ewu_mark_mem, always through ewu_pkg::name.
*/
package ewu_pkg;

  // register byte offsets on the AHB-Lite slave
  localparam logic [7:0] OFF_FEAT     = 8'h00;
  localparam logic [7:0] OFF_SCNT     = 8'h04;
  localparam logic [7:0] OFF_LBA_CUR  = 8'h08;
  localparam logic [7:0] OFF_LBA_PREV = 8'h0C;
  localparam logic [7:0] OFF_CMD      = 8'h10;
  localparam logic [7:0] OFF_DATA     = 8'h14;
  localparam logic [7:0] OFF_ERROR    = 8'h18;
  localparam logic [7:0] OFF_STATUS   = 8'h1C;
  localparam logic [7:0] OFF_CTRL     = 8'h20;
  localparam logic [7:0] OFF_FAIL_LBA = 8'h24;

  // command opcodes
  localparam logic [7:0] OP_WRITE_EXT = 8'h34;
  localparam logic [7:0] OP_MARK_EXT  = 8'h45;

  // uncorrectable option codes
  localparam logic [7:0] FEAT_PSEUDO_LOG   = 8'h55;
  localparam logic [7:0] FEAT_PSEUDO_NOLOG = 8'h5A;
  localparam logic [7:0] FEAT_FLAG_LOG     = 8'hA5;
  localparam logic [7:0] FEAT_FLAG_NOLOG   = 8'hAA;

  // error_flags bit positions
  localparam int ERR_UNC = 6;
  localparam int ERR_IDN = 4;
  localparam int ERR_ABT = 2;

  // device_status bit positions
  localparam int STS_BSY = 7;
  localparam int STS_RDY = 6;
  localparam int STS_DSC = 4;
  localparam int STS_DRQ = 3;
  localparam int STS_ERR = 0;

  // zero count stands for the largest transfer
  localparam logic [16:0] SECT_MAX   = 17'h10000;
  localparam int          WORDS_SECT = 256;
  localparam int          MARK_AW    = 8;

  // reset values
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [23:0] RST_LBA24 = 24'h000000;
  localparam logic [31:0] RST_WORD  = 32'h00000000;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WRITE = 3'b010,
    ST_MARK  = 3'b100
  } ewu_state_t;

  // one mark table entry
  typedef struct packed {
    logic valid;
    logic flagged;
    logic log_en;
  } ewu_mark_t;

  // result of a read lookup handed to the media read path
  typedef struct packed {
    logic done;
    logic uncorrectable_flag;
    logic recover;
    logic log_en;
  } ewu_rdres_t;

endpackage

// ==== rtl/ewu_mark_mem.sv ====
/*
  ewu_mark_mem: mark table, one write port and one registered read port.
  assumes: the array stands for non-volatile storage, so it has no reset
  and keeps its contents through any reset of the logic around it.
*/
`timescale 1ns/10ps
module ewu_mark_mem #(
  parameter int AW = 8
) (
  input  wire logic              i_clk,
  input  wire logic              i_we,
  input  wire logic [AW-1:0]     i_waddr,
  input  ewu_pkg::ewu_mark_t     i_wdata,
  input  wire logic [AW-1:0]     i_raddr,
  output ewu_pkg::ewu_mark_t     o_rdata
);

  ewu_pkg::ewu_mark_t mem_q [0:(1<<AW)-1];
  ewu_pkg::ewu_mark_t rdata_q;

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
    rdata_q <= mem_q[i_raddr];
  end

  assign o_rdata = rdata_q;

endmodule

// ==== rtl/ewu_top.sv ====
/*
  ewu_top: taskfile command engine for the extended write (34h) and the
  mark-uncorrectable (45h) commands, behind an AHB-Lite slave.
  assumes: one clock, zero-wait AHB-Lite master doing single word
  transfers, media write and read paths on the same clock.
*/
`timescale 1ns/10ps
module ewu_top #(
  parameter int WPS = ewu_pkg::WORDS_SECT,
  parameter int AW  = ewu_pkg::MARK_AW
) (
  input  wire logic        I_CLOCK,
  input  wire logic        I_RST_N,
  input  wire logic        I_HSEL,
  input  wire logic [31:0] I_HADDR,
  input  wire logic [1:0]  I_HTRANS,
  input  wire logic        I_HWRITE,
  input  wire logic [2:0]  I_HSIZE,
  input  wire logic [31:0] I_HWDATA,
  input  wire logic        I_HREADY,
  output logic      [31:0] O_HRDATA,
  output logic             O_HREADYOUT,
  output logic             O_HRESP,
  output logic             O_MEDIA_WR_VALID,
  output logic      [15:0] O_MEDIA_WR_DATA,
  output logic      [47:0] O_MEDIA_WR_LBA,
  input  wire logic        I_MEDIA_FAIL,
  input  wire logic        I_RD_REQ,
  input  wire logic [47:0] I_RD_LBA,
  output logic             O_RD_DONE,
  output logic             O_RD_UNC,
  output logic             O_RD_RECOVER,
  output logic             O_RD_LOG
);

  localparam int WW = $clog2(WPS);

  function automatic ewu_pkg::ewu_mark_t feat_dec(input logic [7:0] f);
    ewu_pkg::ewu_mark_t m;
    m = '0;
    case (f)
      ewu_pkg::FEAT_PSEUDO_LOG:   m = '{1'b1, 1'b0, 1'b1};
      ewu_pkg::FEAT_PSEUDO_NOLOG: m = '{1'b1, 1'b0, 1'b0};
      ewu_pkg::FEAT_FLAG_LOG:     m = '{1'b1, 1'b1, 1'b1};
      ewu_pkg::FEAT_FLAG_NOLOG:   m = '{1'b1, 1'b1, 1'b0};
      default:                    m = '0;
    endcase
    return m;
  endfunction

  ewu_pkg::ewu_state_t st_q, st_d;
  logic [7:0]          feat_q, feat_d;
  logic [15:0]         scnt_q, scnt_d;
  logic [23:0]         lcur_q, lcur_d;
  logic [23:0]         lprev_q, lprev_d;
  logic                hob_q, hob_d;
  logic [7:0]          err_q, err_d;
  logic [47:0]         lba_q, lba_d;
  logic [47:0]         fail_q, fail_d;
  logic [16:0]         remain_q, remain_d;
  logic [WW-1:0]       word_q, word_d;
  ewu_pkg::ewu_mark_t  mark_q, mark_d;
  ewu_pkg::ewu_mark_t  fdec;
  logic                dwe_q, dwe_d;
  logic                drd_q, drd_d;
  logic [7:0]          dadr_q, dadr_d;
  logic [31:0]         hrdata_q, hrdata_d;
  logic                mwr_v_q, mwr_v_d;
  logic [15:0]         mwr_dat_q, mwr_dat_d;
  logic [47:0]         mwr_lba_q, mwr_lba_d;
  logic                rd_pend_q;
  ewu_pkg::ewu_rdres_t rres_q, rres_d;
  ewu_pkg::ewu_mark_t  mem_rdata;
  ewu_pkg::ewu_mark_t  mem_wdata;
  logic                mem_we;
  logic [AW-1:0]       mem_waddr;
  logic                aph;
  logic                cmd_go;
  logic                data_go;
  logic [7:0]          status;

  assign aph    = I_HSEL && I_HTRANS[1] && I_HREADY;
  assign fdec   = feat_dec(feat_q);
  assign cmd_go = dwe_q && (dadr_q == ewu_pkg::OFF_CMD) &&
                  (st_q == ewu_pkg::ST_IDLE);
  assign data_go = dwe_q && (dadr_q == ewu_pkg::OFF_DATA) &&
                   (st_q == ewu_pkg::ST_WRITE);

  always_comb begin
    status                   = 8'h00;
    status[ewu_pkg::STS_BSY] = (st_q == ewu_pkg::ST_MARK);
    status[ewu_pkg::STS_RDY] = 1'b1;
    status[ewu_pkg::STS_DSC] = 1'b1;
    status[ewu_pkg::STS_DRQ] = (st_q == ewu_pkg::ST_WRITE);
    status[ewu_pkg::STS_ERR] = (err_q != 8'h00);
  end

  // bus slave: zero wait, read data registered at the address phase
  always_comb begin
    dwe_d    = aph && I_HWRITE;
    drd_d    = aph && !I_HWRITE;
    dadr_d   = aph ? I_HADDR[7:0] : dadr_q;
    hrdata_d = hrdata_q;
    if (aph && !I_HWRITE) begin
      case (I_HADDR[7:0])
        ewu_pkg::OFF_FEAT:     hrdata_d = {24'h000000, feat_q};
        ewu_pkg::OFF_SCNT:     hrdata_d = {16'h0000, scnt_q};
        ewu_pkg::OFF_LBA_CUR:  hrdata_d = {8'h00, lcur_q};
        ewu_pkg::OFF_LBA_PREV: hrdata_d = {8'h00, lprev_q};
        ewu_pkg::OFF_ERROR:    hrdata_d = {24'h000000, err_q};
        ewu_pkg::OFF_STATUS:   hrdata_d = {24'h000000, status};
        ewu_pkg::OFF_CTRL:     hrdata_d = {31'h00000000, hob_q};
        ewu_pkg::OFF_FAIL_LBA: hrdata_d = hob_q ? {8'h00, fail_q[47:24]}
                                                : {8'h00, fail_q[23:0]};
        default:               hrdata_d = ewu_pkg::RST_WORD;
      endcase
    end
  end

  // command engine
  always_comb begin
    st_d      = st_q;
    feat_d    = feat_q;
    scnt_d    = scnt_q;
    lcur_d    = lcur_q;
    lprev_d   = lprev_q;
    hob_d     = hob_q;
    err_d     = err_q;
    lba_d     = lba_q;
    fail_d    = fail_q;
    remain_d  = remain_q;
    word_d    = word_q;
    mark_d    = mark_q;
    mwr_v_d   = 1'b0;
    mwr_dat_d = mwr_dat_q;
    mwr_lba_d = mwr_lba_q;
    mem_we    = 1'b0;
    mem_waddr = lba_q[AW-1:0];
    mem_wdata = '0;
    if (dwe_q && (st_q == ewu_pkg::ST_IDLE)) begin
      case (dadr_q)
        ewu_pkg::OFF_FEAT:     feat_d  = I_HWDATA[7:0];
        ewu_pkg::OFF_SCNT:     scnt_d  = I_HWDATA[15:0];
        ewu_pkg::OFF_LBA_CUR:  lcur_d  = I_HWDATA[23:0];
        ewu_pkg::OFF_LBA_PREV: lprev_d = I_HWDATA[23:0];
        default:               ;
      endcase
    end
    if (dwe_q && (dadr_q == ewu_pkg::OFF_CTRL)) begin
      hob_d = I_HWDATA[0];
    end
    case (st_q)
      ewu_pkg::ST_IDLE: begin
        if (cmd_go) begin
          err_d    = ewu_pkg::RST_BYTE;
          lba_d    = {lprev_q, lcur_q};
          remain_d = (scnt_q == 16'h0000) ? ewu_pkg::SECT_MAX
                                          : {1'b0, scnt_q};
          word_d   = '0;
          if (I_HWDATA[7:0] == ewu_pkg::OP_WRITE_EXT) begin
            st_d = ewu_pkg::ST_WRITE;
          end else if ((I_HWDATA[7:0] == ewu_pkg::OP_MARK_EXT) &&
                       fdec.valid) begin
            st_d   = ewu_pkg::ST_MARK;
            mark_d = fdec;
          end else begin
            err_d[ewu_pkg::ERR_ABT] = 1'b1;
          end
        end
      end
      ewu_pkg::ST_WRITE: begin
        if (I_MEDIA_FAIL) begin
          st_d   = ewu_pkg::ST_IDLE;
          fail_d = lba_q;
          err_d[ewu_pkg::ERR_ABT] = 1'b1;
        end else if (data_go) begin
          mwr_v_d   = 1'b1;
          mwr_dat_d = I_HWDATA[15:0];
          mwr_lba_d = lba_q;
          word_d    = word_q + 1'b1;
          if (word_q == WW'(WPS - 1)) begin
            // rewriting a sector clears any mark it carried
            mem_we   = 1'b1;
            lba_d    = lba_q + 48'h1;
            remain_d = remain_q - 17'h1;
            if (remain_q == 17'h1) begin
              st_d = ewu_pkg::ST_IDLE;
            end
          end
        end
      end
      ewu_pkg::ST_MARK: begin
        if (I_MEDIA_FAIL) begin
          st_d   = ewu_pkg::ST_IDLE;
          fail_d = lba_q;
          err_d[ewu_pkg::ERR_ABT] = 1'b1;
        end else begin
          mem_we    = 1'b1;
          mem_wdata = mark_q;
          lba_d     = lba_q + 48'h1;
          remain_d  = remain_q - 17'h1;
          if (remain_q == 17'h1) begin
            st_d = ewu_pkg::ST_IDLE;
          end
        end
      end
      default: st_d = ewu_pkg::ST_IDLE;
    endcase
  end

  // read lookup: pseudo asks for recovery first, flagged fails at once
  always_comb begin
    rres_d         = '0;
    rres_d.done    = rd_pend_q;
    rres_d.uncorrectable_flag     = rd_pend_q && mem_rdata.valid;
    rres_d.recover = rd_pend_q && mem_rdata.valid && !mem_rdata.flagged;
    rres_d.log_en  = rd_pend_q && mem_rdata.valid && mem_rdata.log_en;
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_q      <= ewu_pkg::ST_IDLE;
      feat_q    <= ewu_pkg::RST_BYTE;
      scnt_q    <= 16'h0000;
      lcur_q    <= ewu_pkg::RST_LBA24;
      lprev_q   <= ewu_pkg::RST_LBA24;
      hob_q     <= 1'b0;
      err_q     <= ewu_pkg::RST_BYTE;
      lba_q     <= 48'h000000000000;
      fail_q    <= 48'h000000000000;
      remain_q  <= 17'h00000;
      word_q    <= '0;
      mark_q    <= '0;
      dwe_q     <= 1'b0;
      drd_q     <= 1'b0;
      dadr_q    <= 8'h00;
      hrdata_q  <= ewu_pkg::RST_WORD;
      mwr_v_q   <= 1'b0;
      mwr_dat_q <= 16'h0000;
      mwr_lba_q <= 48'h000000000000;
      rd_pend_q <= 1'b0;
      rres_q    <= '0;
    end else begin
      st_q      <= st_d;
      feat_q    <= feat_d;
      scnt_q    <= scnt_d;
      lcur_q    <= lcur_d;
      lprev_q   <= lprev_d;
      hob_q     <= hob_d;
      err_q     <= err_d;
      lba_q     <= lba_d;
      fail_q    <= fail_d;
      remain_q  <= remain_d;
      word_q    <= word_d;
      mark_q    <= mark_d;
      dwe_q     <= dwe_d;
      drd_q     <= drd_d;
      dadr_q    <= dadr_d;
      hrdata_q  <= hrdata_d;
      mwr_v_q   <= mwr_v_d;
      mwr_dat_q <= mwr_dat_d;
      mwr_lba_q <= mwr_lba_d;
      rd_pend_q <= I_RD_REQ;
      rres_q    <= rres_d;
    end
  end

  // table indexed by low address bits only: distant sectors alias
  ewu_mark_mem #(
    .AW (AW)
  ) u_mark_mem (
    .i_clk   (I_CLOCK),
    .i_we    (mem_we),
    .i_waddr (mem_waddr),
    .i_wdata (mem_wdata),
    .i_raddr (I_RD_LBA[AW-1:0]),
    .o_rdata (mem_rdata)
  );

  assign O_HRDATA         = hrdata_q;
  assign O_HREADYOUT      = 1'b1;
  assign O_HRESP          = 1'b0;
  assign O_MEDIA_WR_VALID = mwr_v_q;
  assign O_MEDIA_WR_DATA  = mwr_dat_q;
  assign O_MEDIA_WR_LBA   = mwr_lba_q;
  assign O_RD_DONE        = rres_q.done;
  assign O_RD_UNC         = rres_q.uncorrectable_flag;
  assign O_RD_RECOVER     = rres_q.recover;
  assign O_RD_LOG         = rres_q.log_en;

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);
  sequence s_write_cmd;
    cmd_go && (I_HWDATA[7:0] == ewu_pkg::OP_WRITE_EXT);
  endsequence
  AST_WRITE_START: assert property (s_write_cmd |=>
    st_q == ewu_pkg::ST_WRITE && status[ewu_pkg::STS_DRQ])
    else $error("write did not start");
  AST_WORD_FWD: assert property (data_go && !I_MEDIA_FAIL |=>
    mwr_v_q && mwr_dat_q == $past(I_HWDATA[15:0])) else $error("word lost");
  AST_COUNT_ZERO: assert property (cmd_go && scnt_q == 16'h0000 |=>
    remain_q == 17'h10000) else $error("zero count wrong");
  AST_LBA_LOAD: assert property (cmd_go |=> lba_q == {$past(lprev_q),
    $past(lcur_q)}) else $error("start address wrong");
  AST_HOB_READ: assert property (drd_q && $past(hob_q) &&
    dadr_q == ewu_pkg::OFF_FAIL_LBA && $stable(fail_q) |->
    O_HRDATA[23:0] == fail_q[47:24]) else $error("high address bytes wrong");
  AST_FAIL_STOP: assert property (st_q != ewu_pkg::ST_IDLE &&
    I_MEDIA_FAIL |=> st_q == ewu_pkg::ST_IDLE && fail_q == $past(lba_q) &&
    err_q[ewu_pkg::ERR_ABT]) else $error("failure did not stop");
  AST_MARK_WRITE: assert property (st_q == ewu_pkg::ST_MARK &&
    !I_MEDIA_FAIL |-> mem_we && mem_wdata == mark_q) else $error("mark lost");
  AST_PSEUDO_READ: assert property (rd_pend_q && mem_rdata.valid &&
    !mem_rdata.flagged |=> O_RD_UNC && O_RD_RECOVER) else $error("bad pseudo");
  AST_FLAG_READ: assert property (I_RD_REQ ##1 mem_rdata.valid &&
    mem_rdata.flagged |=> O_RD_DONE && O_RD_UNC && !O_RD_RECOVER)
    else $error("flagged read wrong");
  AST_LOG_READ: assert property (rd_pend_q |=> O_RD_LOG ==
    ($past(mem_rdata.valid) && $past(mem_rdata.log_en))) else $error("log");
  AST_BAD_FEAT: assert property (cmd_go && !fdec.valid &&
    I_HWDATA[7:0] == ewu_pkg::OP_MARK_EXT |=> st_q == ewu_pkg::ST_IDLE &&
    err_q[ewu_pkg::ERR_ABT] && O_HREADYOUT) else $error("no abort");

endmodule

// ==== bench/ewu_media_model.sv ====
/*
  ewu_media_model: media side partner; raises write faults and asks the
  mark table about sectors on behalf of later reads.
  assumes: same clock as ewu_top; the bench calls its tasks.
*/
`timescale 1ns/10ps
module ewu_media_model (
  input  wire logic        i_clk,
  output logic             o_fail,
  output logic             o_rd_req,
  output logic      [47:0] o_rd_lba
);
  initial begin
    o_fail   = 1'b0;
    o_rd_req = 1'b0;
    o_rd_lba = 48'h000000000000;
  end

  // one-cycle fault on the sector being written
  task automatic pulse_fail();
    @(posedge i_clk);
    o_fail <= 1'b1;
    @(posedge i_clk);
    o_fail <= 1'b0;
  endtask

  // fast mode asks back to back; a released address shows its inverse so
  // a design that samples late cannot see a stale match
  task automatic lookup(input logic [47:0] q[$], input logic slow);
    foreach (q[i]) begin
      @(posedge i_clk);
      o_rd_req <= 1'b1;
      o_rd_lba <= q[i];
      if (slow) begin
        @(posedge i_clk);
        o_rd_req <= 1'b0;
        o_rd_lba <= ~q[i];
      end
    end
    @(posedge i_clk);
    o_rd_req <= 1'b0;
    o_rd_lba <= ~q[$];
  endtask
endmodule

// ==== bench/test_ext_write_and_uncorrectable_marking.sv ====
/*
  test_ext_write_and_uncorrectable_marking: self-checking bench for ewu_top.
  assumes: zero-wait slave, WPS shortened to 4 words a sector.
*/
`timescale 1ns/10ps
module test_ext_write_and_uncorrectable_marking;
  localparam int WPS = 4;
  logic        clk, rst_n, hsel, hwrite, hready, hresp, fail, rd_req;
  logic        wr_valid, rd_done, rd_unc, rd_rec, rd_log;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, seed, rd;
  logic [15:0] wr_data;
  logic [47:0] wr_lba, rd_lba, base;
  logic [63:0] wq[$];
  logic [2:0]  lq[$];
  logic [7:0]  feat[4] = '{8'h55, 8'h5A, 8'hA5, 8'hAA};
  int          n_errors, samples_checked;

  ewu_top #(.WPS(WPS), .AW(8)) dut_u (
    .I_CLOCK(clk), .I_RST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize),
    .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
    .O_HREADYOUT(hready), .O_HRESP(hresp), .O_MEDIA_WR_VALID(wr_valid),
    .O_MEDIA_WR_DATA(wr_data), .O_MEDIA_WR_LBA(wr_lba),
    .I_MEDIA_FAIL(fail), .I_RD_REQ(rd_req), .I_RD_LBA(rd_lba),
    .O_RD_DONE(rd_done), .O_RD_UNC(rd_unc), .O_RD_RECOVER(rd_rec),
    .O_RD_LOG(rd_log));
  ewu_media_model media_u (.i_clk(clk), .o_fail(fail), .o_rd_req(rd_req),
    .o_rd_lba(rd_lba));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [2:0] mexp(input logic [7:0] f);
    return {1'b1, f[7:4] == 4'h5, f == 8'h55 || f == 8'hA5};
  endfunction

  task automatic stop_test();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one single-word transfer; read data taken at the data-phase edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
                       input string what);
    bus(1'b0, a, 32'h00000000);
    check(what, {32'h00000000, rd}, {32'h00000000, exp});
    check("response", 64'(hresp), 64'h0);
  endtask

  // extra idle cycle: status of a command shows two cycles later
  task automatic start(input logic [7:0] f, input logic [15:0] n,
                       input logic [47:0] lba, input logic [7:0] op);
    bus(1'b1, ewu_pkg::OFF_FEAT, {24'h000000, f});
    bus(1'b1, ewu_pkg::OFF_SCNT, {16'h0000, n});
    bus(1'b1, ewu_pkg::OFF_LBA_CUR, {8'h00, lba[23:0]});
    bus(1'b1, ewu_pkg::OFF_LBA_PREV, {8'h00, lba[47:24]});
    bus(1'b1, ewu_pkg::OFF_CMD, {24'h000000, op});
    @(posedge clk);
  endtask

  task automatic send(input int words, input logic [47:0] lba);
    logic [15:0] d;
    for (int i = 0; i < words; i++) begin
      d = xs();
      wq.push_back({lba + 48'(i / WPS), d});
      bus(1'b1, ewu_pkg::OFF_DATA, {16'h0000, d});
    end
  endtask

  task automatic probe(input logic slow);
    logic [47:0] q[$];
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 2; j++) begin
        q.push_back({base[47:8], 8'(8'h20 + 2 * k + j)});
        lq.push_back(mexp(feat[k]));
      end
    end
    q.push_back({base[47:8], 8'h28});
    lq.push_back(3'b000);
    media_u.lookup(q, slow);
    repeat (4) @(posedge clk);
    check("lookups left", 64'(lq.size()), 64'h0);
  endtask

  // results are matched in order against the oldest note
  always @(posedge clk) begin
    if (wr_valid === 1'b1) begin
      if (wq.size() == 0) check("stray media write", 64'h1, 64'h0);
      else check("media write", {wr_lba, wr_data}, wq.pop_front());
    end
    if (rd_done === 1'b1) begin
      if (lq.size() == 0) check("stray lookup", 64'h1, 64'h0);
      else check("lookup", {rd_unc, rd_rec, rd_log}, lq.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    stop_test();
  end

  initial begin
    seed = 32'h00000021;
    n_errors = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h00000000;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(ewu_pkg::OFF_STATUS, 32'h00000050, "status idle");
    rdchk(8'h30, 32'h00000000, "unmapped");
    bus(1'b1, ewu_pkg::OFF_CTRL, 32'h00000001);
    rdchk(ewu_pkg::OFF_CTRL, 32'h00000001, "select");
    rd = xs();
    base = {rd[15:0], 32'h00ABCDEF};
    // 257 sectors exercises the upper count byte and clears every mark
    start(8'h00, 16'h0101, base, ewu_pkg::OP_WRITE_EXT);
    rdchk(ewu_pkg::OFF_STATUS, 32'h00000058, "status drq");
    send(257 * WPS, base);
    rdchk(ewu_pkg::OFF_STATUS, 32'h00000050, "status done");
    // zero count must still take data after 257 sectors, then a fault cuts it
    start(8'h00, 16'h0000, base + 48'h10000000, ewu_pkg::OP_WRITE_EXT);
    send(257 * WPS + 2, base + 48'h10000000);
    rdchk(ewu_pkg::OFF_STATUS, 32'h00000058, "status zero count");
    media_u.pulse_fail();
    repeat (2) @(posedge clk);
    rdchk(ewu_pkg::OFF_STATUS, 32'h00000051, "status fail");
    rdchk(ewu_pkg::OFF_ERROR, 32'h00000004, "fail abort");
    rd = {8'h00, base[47:24] + 24'h000010};
    rdchk(ewu_pkg::OFF_FAIL_LBA, rd, "fail high");
    bus(1'b1, ewu_pkg::OFF_CTRL, 32'h00000000);
    rd = {8'h00, base[23:0] + 24'h000101};
    rdchk(ewu_pkg::OFF_FAIL_LBA, rd, "fail low");
    bus(1'b1, ewu_pkg::OFF_DATA, 32'h00001234);
    start(8'h50, 16'h0001, base, ewu_pkg::OP_MARK_EXT);
    rdchk(ewu_pkg::OFF_ERROR, 32'h00000004, "bad option");
    rdchk(ewu_pkg::OFF_STATUS, 32'h00000051, "bad status");
    for (int k = 0; k < 4; k++) begin
      start(feat[k], 16'h0002, {base[47:8], 8'(8'h20 + 2 * k)},
            ewu_pkg::OP_MARK_EXT);
      do bus(1'b0, ewu_pkg::OFF_STATUS, 32'h0); while (rd[7] !== 1'b0);
      rdchk(ewu_pkg::OFF_ERROR, 32'h00000000, "mark error");
    end
    probe(1'b0);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(ewu_pkg::OFF_ERROR, 32'h00000000, "error after reset");
    probe(1'b1);
    stop_test();
  end
endmodule
